// *** core/strap_defaults.sv ***
// Purpose: Strap-driven reset defaults for port flow control registers
// Assumes: Straps stable while reset is held and shortly after
// Notes:   Software writes override loaded values until next reset
//
// Overview of operation
// - Port 2 duplex bit defaults from duplex strap, high is full
// - Duplex strap also sets 10BASE-T full advert bit 6 and mode field
// - Port 2 backpressure enable defaults from its strap
// - Port 2 pause strap sets both tx and rx pause enables
// - Port 2 tx and rx enables apply only under manual select
// - Manual strap low: autoneg decides, symmetric pause bit 10 set
// - Manual strap high: enable bits decide, pause bit 10 cleared
// - Host port backpressure enable defaults from its strap
// - Host pause strap sets host tx and rx pause enables
// - Host manual strap sets host manual select default
// - Heartbeat strap sets heartbeat-off bit 0 default
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module strap_defaults
  import strap_cfg_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        p2_duplex_pin,
  input  wire logic        p2_backpressure_pin,
  input  wire logic        p2_pause_enable_pin,
  input  wire logic        p2_manual_pause_pin,
  input  wire logic        host_backpressure_pin,
  input  wire logic        host_pause_enable_pin,
  input  wire logic        host_manual_pause_pin,
  input  wire logic        heartbeat_disable_pin,
  input  wire logic        p2_autoneg_on,
  input  wire logic        p2_an_tx_pause,
  input  wire logic        p2_an_rx_pause,
  input  wire logic        host_autoneg_on,
  input  wire logic        host_an_tx_pause,
  input  wire logic        host_an_rx_pause,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output flow_t            p2_flow,
  output flow_t            host_flow,
  output logic             p2_full_duplex,
  output logic             heartbeat_test_off,
  output logic             load_done
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LD_WAIT = 2'b00,
    LD_LOAD = 2'b01,
    LD_DONE = 2'b10
  } load_state_t;

  load_state_t  load_st_r;
  logic [3:0]   cap_cnt_r;
  strap_t       straps;
  logic         p2_duplex_r;
  logic [31:0]  p2_advertise_r;
  logic [2:0]   p2_mode_r;
  logic         p2_backpressure_enable;
  logic         p2_tx_pause_enable;
  logic         p2_rx_pause_enable;
  logic         p2_manual_pause_select;
  logic         host_backpressure_enable;
  logic         host_tx_pause_enable;
  logic         host_rx_pause_enable;
  logic         host_manual_pause_select;
  logic         heartbeat_off_r;
  logic         aw_hold_r;
  logic         w_hold_r;
  logic [7:0]   awaddr_r;
  logic [31:0]  wdata_r;
  logic [3:0]   wstrb_r;
  logic         wr_fire;
  logic         wr_hit;
  logic         loading;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == P2_BASIC_OFS) || (a == P2_ADVERT_OFS) ||
           (a == P2_MODES_OFS) || (a == P2_FLOW_OFS) ||
           (a == HOST_FLOW_OFS) || (a == VPHY_SPEC_OFS) ||
           (a == STATUS_OFS);
  endfunction : mapped

  assign straps = '{p2_duplex_pin, p2_backpressure_pin, p2_pause_enable_pin,
                    p2_manual_pause_pin, host_backpressure_pin,
                    host_pause_enable_pin, host_manual_pause_pin,
                    heartbeat_disable_pin};

  // ----------------------------------------------------------------------
  // Strap capture sequence
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_st_r <= LD_WAIT;
      cap_cnt_r <= 4'h0;
    end else if (clk_en) begin
      case (load_st_r)
        LD_WAIT: begin
          if (cap_cnt_r == CAPTURE_CYCLES - 4'h1) begin
            load_st_r <= LD_LOAD;
          end else begin
            cap_cnt_r <= cap_cnt_r + 4'h1;
          end
        end
        LD_LOAD: load_st_r <= LD_DONE;
        LD_DONE: load_st_r <= LD_DONE;
        default: load_st_r <= LD_WAIT;
      endcase
    end
  end

  assign loading   = (load_st_r == LD_LOAD);
  assign load_done = (load_st_r == LD_DONE);

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = load_done && !aw_hold_r && !s_axi_bvalid && clk_en;
  assign s_axi_wready  = load_done && !w_hold_r && !s_axi_bvalid && clk_en;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_hit        = wr_fire && mapped(awaddr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= 8'h00;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Configuration registers: strap load, then software
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p2_duplex_r    <= 1'b0;
      p2_advertise_r <= ADVERT_BASE_RST;
      p2_mode_r      <= 3'h0;
    end else if (clk_en) begin
      if (loading) begin
        p2_duplex_r <= straps.p2_duplex;
        p2_advertise_r <= ADVERT_BASE_RST;
        p2_advertise_r[ADV_10FD_BIT] <= straps.p2_duplex;
        p2_advertise_r[ADV_PAUSE_BIT] <= !straps.p2_manual_pause;
        p2_mode_r <= straps.p2_duplex ? MODE_FD_VAL : MODE_HD_VAL;
      end else if (wr_hit) begin
        if (awaddr_r == P2_BASIC_OFS && wstrb_r[1]) begin
          p2_duplex_r <= wdata_r[DUPLEX_BIT];
        end
        if (awaddr_r == P2_ADVERT_OFS) begin
          p2_advertise_r <= merge(p2_advertise_r, wdata_r, wstrb_r);
        end
        if (awaddr_r == P2_MODES_OFS && wstrb_r[0]) begin
          p2_mode_r <= wdata_r[MODE_LSB +: 3];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p2_backpressure_enable   <= 1'b0;
      p2_tx_pause_enable       <= 1'b0;
      p2_rx_pause_enable       <= 1'b0;
      p2_manual_pause_select   <= 1'b0;
      host_backpressure_enable <= 1'b0;
      host_tx_pause_enable     <= 1'b0;
      host_rx_pause_enable     <= 1'b0;
      host_manual_pause_select <= 1'b0;
      heartbeat_off_r          <= 1'b0;
    end else if (clk_en) begin
      if (loading) begin
        p2_backpressure_enable   <= straps.p2_backpressure;
        p2_tx_pause_enable       <= straps.p2_pause_enable;
        p2_rx_pause_enable       <= straps.p2_pause_enable;
        p2_manual_pause_select   <= straps.p2_manual_pause;
        host_backpressure_enable <= straps.host_backpressure;
        host_tx_pause_enable     <= straps.host_pause_enable;
        host_rx_pause_enable     <= straps.host_pause_enable;
        host_manual_pause_select <= straps.host_manual_pause;
        heartbeat_off_r          <= straps.heartbeat_disable;
      end else if (wr_hit && wstrb_r[0]) begin
        if (awaddr_r == P2_FLOW_OFS) begin
          p2_backpressure_enable <= wdata_r[FLOW_BP_BIT];
          p2_rx_pause_enable     <= wdata_r[FLOW_RX_BIT];
          p2_tx_pause_enable     <= wdata_r[FLOW_TX_BIT];
          p2_manual_pause_select <= wdata_r[FLOW_MANUAL_BIT];
        end
        if (awaddr_r == HOST_FLOW_OFS) begin
          host_backpressure_enable <= wdata_r[FLOW_BP_BIT];
          host_rx_pause_enable     <= wdata_r[FLOW_RX_BIT];
          host_tx_pause_enable     <= wdata_r[FLOW_TX_BIT];
          host_manual_pause_select <= wdata_r[FLOW_MANUAL_BIT];
        end
        if (awaddr_r == VPHY_SPEC_OFS) begin
          heartbeat_off_r <= wdata_r[HEARTBEAT_BIT];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  assign s_axi_arready = load_done && !s_axi_rvalid && clk_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
        s_axi_rdata  <= 32'h0000_0000;
        case (s_axi_araddr)
          P2_BASIC_OFS:  s_axi_rdata[DUPLEX_BIT] <= p2_duplex_r;
          P2_ADVERT_OFS: s_axi_rdata <= p2_advertise_r;
          P2_MODES_OFS:  s_axi_rdata[MODE_LSB +: 3] <= p2_mode_r;
          P2_FLOW_OFS:   s_axi_rdata[3:0] <= {p2_manual_pause_select,
                           p2_tx_pause_enable, p2_rx_pause_enable,
                           p2_backpressure_enable};
          HOST_FLOW_OFS: s_axi_rdata[3:0] <= {host_manual_pause_select,
                           host_tx_pause_enable, host_rx_pause_enable,
                           host_backpressure_enable};
          VPHY_SPEC_OFS: s_axi_rdata[HEARTBEAT_BIT] <= heartbeat_off_r;
          STATUS_OFS:    s_axi_rdata[5:0] <= {p2_flow, host_flow};
          default:       s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Effective flow control
  // ----------------------------------------------------------------------
  flow_resolve u_p2_resolve (
    .manual_select (p2_manual_pause_select),
    .tx_enable     (p2_tx_pause_enable),
    .rx_enable     (p2_rx_pause_enable),
    .backpressure  (p2_backpressure_enable),
    .autoneg_on    (p2_autoneg_on),
    .an_tx_pause   (p2_an_tx_pause),
    .an_rx_pause   (p2_an_rx_pause),
    .flow          (p2_flow)
  );

  flow_resolve u_host_resolve (
    .manual_select (host_manual_pause_select),
    .tx_enable     (host_tx_pause_enable),
    .rx_enable     (host_rx_pause_enable),
    .backpressure  (host_backpressure_enable),
    .autoneg_on    (host_autoneg_on),
    .an_tx_pause   (host_an_tx_pause),
    .an_rx_pause   (host_an_rx_pause),
    .flow          (host_flow)
  );

  assign p2_full_duplex     = p2_duplex_r;
  assign heartbeat_test_off = heartbeat_off_r;

endmodule : strap_defaults

// *** core/strap_cfg_pkg.sv ***
// Purpose: Constants and types for the strap default loader
// Assumes: 32-bit AXI4-Lite register access, word aligned
// Notes:   Offsets are byte addresses
package strap_cfg_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] P2_BASIC_OFS    = 8'h00;
  localparam logic [7:0] P2_ADVERT_OFS   = 8'h04;
  localparam logic [7:0] P2_MODES_OFS    = 8'h08;
  localparam logic [7:0] P2_FLOW_OFS     = 8'h0C;
  localparam logic [7:0] HOST_FLOW_OFS   = 8'h10;
  localparam logic [7:0] VPHY_SPEC_OFS   = 8'h14;
  localparam logic [7:0] STATUS_OFS      = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int DUPLEX_BIT       = 8;
  localparam int ADV_10FD_BIT     = 6;
  localparam int ADV_PAUSE_BIT    = 10;
  localparam int FLOW_BP_BIT      = 0;
  localparam int FLOW_RX_BIT      = 1;
  localparam int FLOW_TX_BIT      = 2;
  localparam int FLOW_MANUAL_BIT  = 3;
  localparam int HEARTBEAT_BIT    = 0;
  localparam int MODE_LSB         = 5;

  // ----------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADVERT_BASE_RST = 32'h0000_0001;
  localparam logic [2:0]  MODE_FD_VAL     = 3'h7;
  localparam logic [2:0]  MODE_HD_VAL     = 3'h6;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;
  localparam logic [3:0]  CAPTURE_CYCLES  = 4'h4;

  typedef struct packed {
    logic p2_duplex;
    logic p2_backpressure;
    logic p2_pause_enable;
    logic p2_manual_pause;
    logic host_backpressure;
    logic host_pause_enable;
    logic host_manual_pause;
    logic heartbeat_disable;
  } strap_t;

  typedef struct packed {
    logic backpressure;
    logic tx_pause;
    logic rx_pause;
  } flow_t;

endpackage : strap_cfg_pkg

// *** core/flow_resolve.sv ***
// Purpose: Resolves effective pause enables for one port
// Assumes: Autoneg result supplied by the PHY side
// Notes:   Manual select picks register bits over negotiation
`timescale 1ns/1ps
module flow_resolve
  import strap_cfg_pkg::*;
(
  input  wire logic  manual_select,
  input  wire logic  tx_enable,
  input  wire logic  rx_enable,
  input  wire logic  backpressure,
  input  wire logic  autoneg_on,
  input  wire logic  an_tx_pause,
  input  wire logic  an_rx_pause,
  output flow_t      flow
);

  // ----------------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------------
  always_comb begin
    flow.backpressure = backpressure;
    if (manual_select) begin
      flow.tx_pause = tx_enable;
      flow.rx_pause = rx_enable;
    end else begin
      flow.tx_pause = autoneg_on & an_tx_pause;
      flow.rx_pause = autoneg_on & an_rx_pause;
    end
  end

endmodule : flow_resolve

// *** verification/strap_defaults_properties.sv ***
// Purpose: Port assertions for the strap default loader
// Assumes: clk_en high except in the freeze case
// Notes:   Attached by bind after the module
`timescale 1ns/1ps
module strap_checker
  import strap_cfg_pkg::*;
(
  input wire logic  aclk,
  input wire logic  aresetn,
  input wire logic  p2_duplex_pin,
  input wire logic  p2_backpressure_pin,
  input wire logic  p2_pause_enable_pin,
  input wire logic  p2_manual_pause_pin,
  input wire logic  host_backpressure_pin,
  input wire logic  host_pause_enable_pin,
  input wire logic  host_manual_pause_pin,
  input wire logic  heartbeat_disable_pin,
  input wire logic  p2_autoneg_on,
  input wire logic  p2_an_tx_pause,
  input wire logic  p2_an_rx_pause,
  input wire logic  host_autoneg_on,
  input wire logic  host_an_tx_pause,
  input wire logic  s_axi_awready,
  input wire logic  s_axi_arvalid,
  input wire logic  s_axi_arready,
  input wire logic  s_axi_rvalid,
  input wire flow_t p2_flow,
  input wire flow_t host_flow,
  input wire logic  p2_full_duplex,
  input wire logic  heartbeat_test_off,
  input wire logic  load_done
);
  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence loaded_s;
    $rose(load_done);
  endsequence
  sequence p2_man_s;
    loaded_s ##0 p2_manual_pause_pin;
  endsequence
  sequence p2_auto_s;
    loaded_s ##0 !p2_manual_pause_pin;
  endsequence
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  ready_gate_a: assert property (
    !load_done |-> !s_axi_awready && !s_axi_arready)
    else $error("bus ready before load done");
  duplex_load_a: assert property (
    loaded_s |-> p2_full_duplex == p2_duplex_pin)
    else $error("duplex default wrong");
  heartbeat_load_a: assert property (
    loaded_s |-> heartbeat_test_off == heartbeat_disable_pin)
    else $error("heartbeat default wrong");
  backpressure_load_a: assert property (
    loaded_s |-> p2_flow.backpressure == p2_backpressure_pin
      && host_flow.backpressure == host_backpressure_pin)
    else $error("backpressure default wrong");
  p2_manual_a: assert property (
    p2_man_s |-> p2_flow.tx_pause == p2_pause_enable_pin
      && p2_flow.rx_pause == p2_pause_enable_pin)
    else $error("port 2 manual pause wrong");
  p2_autoneg_a: assert property (
    p2_auto_s |-> p2_flow.tx_pause == (p2_autoneg_on && p2_an_tx_pause)
      && p2_flow.rx_pause == (p2_autoneg_on && p2_an_rx_pause))
    else $error("port 2 negotiated pause wrong");
  host_pause_a: assert property (
    loaded_s |-> host_flow.tx_pause == (host_manual_pause_pin ?
      host_pause_enable_pin : host_autoneg_on && host_an_tx_pause))
    else $error("host pause default wrong");
  pins_ignored_a: assert property (
    load_done && $changed(p2_duplex_pin) |=> $stable(p2_full_duplex) [*3])
    else $error("duplex follows pin after load");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : strap_checker

bind strap_defaults strap_checker u_chk (
  .aclk, .aresetn, .p2_duplex_pin, .p2_backpressure_pin,
  .p2_pause_enable_pin, .p2_manual_pause_pin, .host_backpressure_pin,
  .host_pause_enable_pin, .host_manual_pause_pin, .heartbeat_disable_pin,
  .p2_autoneg_on, .p2_an_tx_pause, .p2_an_rx_pause, .host_autoneg_on,
  .host_an_tx_pause, .s_axi_awready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .p2_flow, .host_flow, .p2_full_duplex,
  .heartbeat_test_off, .load_done
);

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the strap default loader
// Assumes: Full byte strobes
// Notes:   Strap rows first, then override and bus error cases
`timescale 1ns/1ps
module tb_top
  import strap_cfg_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        clk_en = 1'b1;
  strap_t      sp = '0;
  logic [5:0]  an = 6'h00;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, load_done;
  logic        p2_full_duplex, heartbeat_test_off;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  flow_t       p2_flow, host_flow;
  int          n_errors = 0;
  int          n_compared = 0;
  // Straps, autoneg inputs, expected status
  logic [19:0] rows [5] = '{{8'hFF, 6'h00, 6'h3F}, {8'h00, 6'h3F, 6'h1B},
    {8'hA5, 6'h34, 6'h10}, {8'h5A, 6'h3F, 6'h24}, {8'hC3, 6'h1B, 6'h20}};

  always #2.5 aclk = ~aclk;

  strap_defaults DUT (
    .aclk, .aresetn, .clk_en,
    .p2_duplex_pin(sp.p2_duplex), .p2_backpressure_pin(sp.p2_backpressure),
    .p2_pause_enable_pin(sp.p2_pause_enable),
    .p2_manual_pause_pin(sp.p2_manual_pause),
    .host_backpressure_pin(sp.host_backpressure),
    .host_pause_enable_pin(sp.host_pause_enable),
    .host_manual_pause_pin(sp.host_manual_pause),
    .heartbeat_disable_pin(sp.heartbeat_disable),
    .p2_autoneg_on(an[5]), .p2_an_tx_pause(an[4]), .p2_an_rx_pause(an[3]),
    .host_autoneg_on(an[2]), .host_an_tx_pause(an[1]),
    .host_an_rx_pause(an[0]), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .p2_flow, .host_flow,
    .p2_full_duplex, .heartbeat_test_off, .load_done
  );

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w, aw_t, w_t;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge aclk);
      aw_t = s_axi_awready;
      w_t = s_axi_wready;
      @(posedge aclk);
      if (aw && aw_t) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && w_t) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ready low", s_axi_arready, 1'b0);
    do @(posedge aclk); while (load_done !== 1'b1);
  endtask : rst

  task automatic check_row(input logic [7:0] s, input logic [5:0] st);
    logic [31:0] d;
    logic [1:0]  r;
    rd(P2_BASIC_OFS, d, r);
    chk("duplex bit", d[DUPLEX_BIT], s[7]);
    chk("read resp", r, AXI_OKAY);
    rd(P2_ADVERT_OFS, d, r);
    chk("adv 10fd", d[ADV_10FD_BIT], s[7]);
    chk("adv pause", d[ADV_PAUSE_BIT], !s[4]);
    rd(P2_MODES_OFS, d, r);
    chk("mode", d[MODE_LSB+:3], s[7] ? MODE_FD_VAL : MODE_HD_VAL);
    rd(P2_FLOW_OFS, d, r);
    chk("p2 flow reg", d[3:0], {s[4], s[5], s[5], s[6]});
    rd(HOST_FLOW_OFS, d, r);
    chk("host flow reg", d[3:0], {s[1], s[2], s[2], s[3]});
    rd(VPHY_SPEC_OFS, d, r);
    chk("heartbeat", d[HEARTBEAT_BIT], s[0]);
    rd(STATUS_OFS, d, r);
    chk("status", d[5:0], st);
    chk("p2 flow out", p2_flow, st[5:3]);
    chk("host flow out", host_flow, st[2:0]);
    chk("duplex out", p2_full_duplex, s[7]);
    chk("heartbeat out", heartbeat_test_off, s[0]);
  endtask : check_row

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      sp <= rows[i][19:12];
      an <= rows[i][11:6];
      rst();
      check_row(rows[i][19:12], rows[i][5:0]);
      $display("row %0d done", i);
    end
    wr(P2_FLOW_OFS, 32'h0000_000E, r);
    chk("write resp", r, AXI_OKAY);
    wr(P2_ADVERT_OFS, 32'h0000_0000, r);
    @(posedge aclk);
    sp <= 8'h3C;
    rd(STATUS_OFS, d, r);
    chk("override status", d[5:3], 3'h3);
    rd(P2_ADVERT_OFS, d, r);
    chk("override adv", d[ADV_PAUSE_BIT], 1'b0);
    chk("duplex held", p2_full_duplex, 1'b1);
    $display("override test done");
    rst();
    check_row(8'h3C, 6'h1C);
    wr(8'h40, 32'hFFFF_FFFF, r);
    chk("unmapped wresp", r, AXI_SLVERR);
    rd(8'h40, d, r);
    chk("unmapped rresp", r, AXI_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    $display("unmapped test done");
    @(posedge aclk);
    clk_en <= 1'b0;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("frozen load", load_done, 1'b0);
    chk("frozen ready", s_axi_arready, 1'b0);
    clk_en <= 1'b1;
    do @(posedge aclk); while (load_done !== 1'b1);
    check_row(8'h3C, 6'h1C);
    $display("freeze test done");
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
endmodule : tb_top
